// [sleep_gate_pkg.sv]
// constants and carriers for the peripheral sleep and clock gating block
package sleep_gate_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int BYTE_W = 8;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_SLEEP_ENABLE_2 = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_CLOCK_NEEDED_2 = 8'h28;

  // bits that steer a real peripheral: 28..9 and 3
  localparam logic [DATA_W-1:0] PERIPH_MASK = 32'h1FFF_FE08;
  // held-only storage bits 8..4
  localparam logic [DATA_W-1:0] SPARE_MASK = 32'h0000_01F0;
  // every bit that software can write
  localparam logic [DATA_W-1:0] WRITE_MASK = 32'h1FFF_FFF8;
  localparam logic [DATA_W-1:0] RESET_VALUE = 32'h0000_0000;
  localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

  // peripheral bit positions
  localparam int BIT_CIPHER_HASH = 28;
  localparam int BIT_RANDOM_GENERATOR = 27;
  localparam int BIT_PUBLIC_KEY_ENGINE = 26;
  localparam int BIT_LIGHT_DRIVER_THREE = 25;
  localparam int BIT_WIDE_TIMER_ONE = 24;
  localparam int BIT_WIDE_TIMER_ZERO = 23;
  localparam int BIT_NARROW_TIMER_THREE = 22;
  localparam int BIT_NARROW_TIMER_TWO = 21;
  localparam int BIT_SERIAL_FLASH_PORT_ONE = 20;
  localparam int BIT_BUS_CONTROL_MODULE = 19;
  localparam int BIT_LIGHT_DRIVER_TWO = 18;
  localparam int BIT_LIGHT_DRIVER_ONE = 17;
  localparam int BIT_LIGHT_DRIVER_ZERO = 16;
  localparam int BIT_SMBUS_CONTROLLER_THREE = 15;
  localparam int BIT_SMBUS_CONTROLLER_TWO = 14;
  localparam int BIT_SMBUS_CONTROLLER_ONE = 13;
  localparam int BIT_FAN_SPEED_PWM = 12;
  localparam int BIT_KEY_MATRIX_SCANNER = 11;
  localparam int BIT_HIBERNATION_TIMER = 10;
  localparam int BIT_SERIAL_FLASH_PORT_ZERO = 9;
  localparam int BIT_CONVERTER = 3;

  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata;
    logic [BE_W-1:0] byteenable;
  } av_req_t;

  typedef struct packed {
    logic waitrequest;
    logic [DATA_W-1:0] readdata;
  } av_rsp_t;
endpackage

// [peripheral_sleep_clock_gating.sv]
// peripheral sleep enables, clock-needed status and clock gate controls
//
// Overview of operation
// RULE1 - sleep bit 1 commands peripheral (bits 28..9 and 3) to sleep when ready
// RULE2 - sleep bit 0 leaves peripheral clock free; sleep bits are read/write, reset 0
// RULE3 - clock-needed bits 28..9 and 3 read-only, 1 while the peripheral needs its clock
// RULE4 - clock-needed bit reads 0 when peripheral needs no clock; resets to 0
// RULE5 - sleep bits 8..4 are plain read/write storage, reset 0, no function
// RULE6 - software also powers down converter reference for lowest deep-sleep current
// RULE7 - random generator sleep bit powers it off at once; its clock-needed drops
// RULE8 - clock stops only while sleep bit is 1 and clock-needed bit is 0
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
module peripheral_sleep_clock_gating (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire sleep_gate_pkg::av_req_t i_av,
  output sleep_gate_pkg::av_rsp_t o_av,
  input wire logic [sleep_gate_pkg::DATA_W-1:0] i_clk_needed,
  output logic [sleep_gate_pkg::DATA_W-1:0] o_sleep_cmd,
  output logic [sleep_gate_pkg::DATA_W-1:0] o_clk_enable,
  output logic o_rng_power_off
);
  import sleep_gate_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] sleep_enable;
    logic [DATA_W-1:0] clk_needed;
    logic [DATA_W-1:0] sleep_cmd;
    logic [DATA_W-1:0] clk_enable;
    logic rng_power_off;
    av_rsp_t rsp;
  } state_t;

  state_t state_r;
  state_t state_nxt;
  logic req_live;
  logic access_done;
  logic [DATA_W-1:0] wr_bits;

  assign req_live = i_av.read | i_av.write;
  // transfer completes at the edge where waitrequest is seen low
  assign access_done = req_live & ~state_r.rsp.waitrequest;

  always_comb begin
    state_nxt = state_r;
    wr_bits = '0;
    for (int b = 0; b < BE_W; b++) begin
      wr_bits[b*BYTE_W +: BYTE_W] = {BYTE_W{i_av.byteenable[b]}};
    end
    // one wait state, then one cycle with waitrequest low
    state_nxt.rsp.waitrequest = 1'b1;
    state_nxt.rsp.readdata = READ_ZERO;
    if (req_live && state_r.rsp.waitrequest) begin
      state_nxt.rsp.waitrequest = 1'b0;
      if (i_av.read) begin
        unique case (i_av.address)
          OFS_SLEEP_ENABLE_2: state_nxt.rsp.readdata = state_r.sleep_enable; // [RULE2] [RULE5]
          OFS_CLOCK_NEEDED_2: state_nxt.rsp.readdata = state_r.clk_needed; // [RULE3]
          default: state_nxt.rsp.readdata = READ_ZERO;
        endcase
      end
    end
    if (access_done && i_av.write && i_av.address == OFS_SLEEP_ENABLE_2) begin
      // writable bits only; clock-needed register ignores writes
      state_nxt.sleep_enable = (state_r.sleep_enable & ~(wr_bits & WRITE_MASK)) |
                               (i_av.writedata & wr_bits & WRITE_MASK); // [RULE2] [RULE5]
    end
    // live request levels, random generator forced low while powered off
    state_nxt.clk_needed = i_clk_needed & PERIPH_MASK; // [RULE3] [RULE4]
    if (state_nxt.sleep_enable[BIT_RANDOM_GENERATOR]) begin
      state_nxt.clk_needed[BIT_RANDOM_GENERATOR] = 1'b0; // [RULE7]
    end
    state_nxt.sleep_cmd = state_nxt.sleep_enable & PERIPH_MASK; // [RULE1]
    // gate only once the peripheral has let go of its clock
    state_nxt.clk_enable = ~(state_nxt.sleep_cmd & ~state_nxt.clk_needed) & PERIPH_MASK; // [RULE8] [RULE2]
    if (state_nxt.sleep_enable[BIT_RANDOM_GENERATOR]) begin
      state_nxt.clk_enable[BIT_RANDOM_GENERATOR] = 1'b0; // [RULE7]
    end
    state_nxt.rng_power_off = state_nxt.sleep_enable[BIT_RANDOM_GENERATOR]; // [RULE7]
    if (i_srst) begin
      state_nxt.sleep_enable = RESET_VALUE; // [RULE2] [RULE5]
      state_nxt.clk_needed = RESET_VALUE; // [RULE4]
      state_nxt.sleep_cmd = RESET_VALUE;
      state_nxt.clk_enable = PERIPH_MASK;
      state_nxt.rng_power_off = 1'b0;
      state_nxt.rsp.waitrequest = 1'b1;
      state_nxt.rsp.readdata = READ_ZERO;
    end
  end

  always_ff @(posedge i_clk) begin
    state_r <= state_nxt;
  end

  assign o_av = state_r.rsp;
  assign o_sleep_cmd = state_r.sleep_cmd;
  assign o_clk_enable = state_r.clk_enable;
  assign o_rng_power_off = state_r.rng_power_off;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  logic wr_sleep_full;
  assign wr_sleep_full = access_done && i_av.write && i_av.address == OFS_SLEEP_ENABLE_2 &&
                         (&i_av.byteenable);

  a_sleep_cmd_write: assert property ( // [RULE1]
    wr_sleep_full |=> o_sleep_cmd == ($past(i_av.writedata) & PERIPH_MASK))
    else $error("sleep command does not follow written sleep enable");

  a_awake_clock_on: assert property ( // [RULE2]
    ((o_sleep_cmd == '0) && !$past(i_srst)) |-> (o_clk_enable == PERIPH_MASK))
    else $error("clock gated while no sleep bit set");

  a_reset_clears: assert property ( // [RULE2]
    $past(i_srst) |-> (state_r.sleep_enable == RESET_VALUE && o_sleep_cmd == RESET_VALUE))
    else $error("sleep enables not zero after reset");

  a_status_tracks: assert property ( // [RULE3]
    (!$past(i_srst) && !state_r.sleep_enable[BIT_RANDOM_GENERATOR]) |->
      state_r.clk_needed == ($past(i_clk_needed) & PERIPH_MASK))
    else $error("clock-needed status does not follow peripheral request");

  a_status_read: assert property ( // [RULE3]
    (i_av.read && i_av.address == OFS_CLOCK_NEEDED_2 && o_av.waitrequest) ##1 !o_av.waitrequest |->
      o_av.readdata == $past(state_r.clk_needed))
    else $error("status read returns wrong value");

  a_status_low: assert property ( // [RULE4]
    (!$past(i_srst) && ($past(i_clk_needed) == '0)) |-> state_r.clk_needed == '0)
    else $error("clock-needed bit set without request");

  a_spare_store: assert property ( // [RULE5]
    (access_done && i_av.write && i_av.address == OFS_SLEEP_ENABLE_2 && (&i_av.byteenable[1:0])) |=>
      ((state_r.sleep_enable & SPARE_MASK) == ($past(i_av.writedata) & SPARE_MASK)) &&
      ((o_sleep_cmd & SPARE_MASK) == '0))
    else $error("spare sleep bits not stored or leak into commands");

  a_rng_off_now: assert property ( // [RULE7]
    state_r.sleep_enable[BIT_RANDOM_GENERATOR] |->
      (o_rng_power_off && !o_clk_enable[BIT_RANDOM_GENERATOR] && !state_r.clk_needed[BIT_RANDOM_GENERATOR]))
    else $error("random generator not powered off at once");

  a_gate_rule: assert property ( // [RULE8]
    !$past(i_srst) |->
      ((~o_clk_enable & PERIPH_MASK & ~(32'h0000_0001 << BIT_RANDOM_GENERATOR)) ==
       (o_sleep_cmd & ~state_r.clk_needed & ~(32'h0000_0001 << BIT_RANDOM_GENERATOR))))
    else $error("clock gated against sleep or clock-needed state");

  a_wait_bounded: assert property (
    (req_live && o_av.waitrequest) |-> ##[1:2] !o_av.waitrequest)
    else $error("bus request never answered");

  c_sleep_then_gate: cover property (
    o_sleep_cmd[BIT_SMBUS_CONTROLLER_ONE] && o_clk_enable[BIT_SMBUS_CONTROLLER_ONE]
      ##[1:20] !o_clk_enable[BIT_SMBUS_CONTROLLER_ONE]);
  c_rng_off: cover property ($rose(o_rng_power_off));
  c_status_read: cover property (access_done && i_av.read && i_av.address == OFS_CLOCK_NEEDED_2 &&
                                 o_av.readdata != '0);
  c_wake: cover property ($fell(o_sleep_cmd[BIT_CONVERTER]));
endmodule // peripheral_sleep_clock_gating

// [periph_model.sv]
// peripheral side model: clock requests that yield to sleep commands
`timescale 1ns/10ps
module periph_model (
  input wire logic i_clk,
  input wire logic [31:0] i_want,
  input wire logic [31:0] i_busy,
  input wire logic [31:0] i_sleep_cmd,
  output logic [31:0] o_clk_needed
);
  // converter reference powerdown stays with software, no signal here
  // a busy peripheral keeps its request until its work is done, then yields
  always_ff @(posedge i_clk) begin
    o_clk_needed <= i_want & ~(i_sleep_cmd & ~i_busy);
  end
endmodule // periph_model

// [peripheral_sleep_clock_gating_tb.sv]
// self-checking bench for the peripheral sleep and clock gating block
`timescale 1ns/10ps
module peripheral_sleep_clock_gating_tb;
  import sleep_gate_pkg::*;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  av_req_t av = '0;
  av_rsp_t rsp;
  logic [31:0] want = '0;
  logic [31:0] busy = '0;
  logic [31:0] need, sleep_cmd, clk_en, q;
  logic rng_off;
  int n_fail = 0;
  int n_compared = 0;
  localparam logic [31:0] RNG_BIT = 32'h0000_0001 << BIT_RANDOM_GENERATOR;
  always #5 i_clk = ~i_clk;
  peripheral_sleep_clock_gating DUT (.i_clk(i_clk), .i_srst(i_srst), .i_av(av), .o_av(rsp),
    .i_clk_needed(need), .o_sleep_cmd(sleep_cmd), .o_clk_enable(clk_en), .o_rng_power_off(rng_off));
  periph_model peers (.i_clk(i_clk), .i_want(want), .i_busy(busy), .i_sleep_cmd(sleep_cmd),
    .o_clk_needed(need));
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    av.read <= ~wr;
    av.write <= wr;
    av.address <= a;
    av.writedata <= d;
    av.byteenable <= 4'hF;
    // wait for the answer; only the watchdog ends a hung wait
    do begin
      @(posedge i_clk);
    end while (rsp.waitrequest !== 1'b0);
    q = rsp.readdata;
    av.read <= 1'b0;
    av.write <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic t_reset();
    bus(1'b0, OFS_SLEEP_ENABLE_2, '0);
    chk("sleep_enable", RESET_VALUE, q);
    bus(1'b0, OFS_CLOCK_NEEDED_2, '0);
    chk("clock_needed", RESET_VALUE, q);
    chk("clk_enable", PERIPH_MASK, clk_en);
    bus(1'b0, 8'h30, '0);
    chk("unmapped", READ_ZERO, q);
  endtask
  task automatic t_regs();
    bus(1'b1, OFS_SLEEP_ENABLE_2, 32'hFFFF_FFFF);
    chk("sleep_cmd", PERIPH_MASK, sleep_cmd);
    chk("rng_power_off", 32'h0000_0001, rng_off);
    bus(1'b1, OFS_CLOCK_NEEDED_2, 32'hFFFF_FFFF);
    bus(1'b1, 8'h30, 32'h0000_0000);
    bus(1'b0, OFS_SLEEP_ENABLE_2, '0);
    chk("sleep_enable", WRITE_MASK, q);
    bus(1'b0, OFS_CLOCK_NEEDED_2, '0);
    chk("clock_needed", READ_ZERO, q);
    bus(1'b1, OFS_SLEEP_ENABLE_2, SPARE_MASK);
    bus(1'b0, OFS_SLEEP_ENABLE_2, '0);
    chk("spare_bits", SPARE_MASK, q);
    chk("sleep_cmd", 32'h0000_0000, sleep_cmd);
  endtask
  task automatic t_gate();
    want <= PERIPH_MASK;
    busy <= PERIPH_MASK;
    bus(1'b1, OFS_SLEEP_ENABLE_2, PERIPH_MASK);
    repeat (3) @(posedge i_clk);
    bus(1'b0, OFS_CLOCK_NEEDED_2, '0);
    chk("clock_needed", PERIPH_MASK & ~RNG_BIT, q);
    chk("clk_enable", PERIPH_MASK & ~RNG_BIT, clk_en);
    busy <= '0;
    repeat (3) @(posedge i_clk);
    chk("clk_enable", 32'h0000_0000, clk_en);
    bus(1'b0, OFS_CLOCK_NEEDED_2, '0);
    chk("clock_needed", READ_ZERO, q);
    bus(1'b1, OFS_SLEEP_ENABLE_2, '0);
    chk("clk_enable", PERIPH_MASK, clk_en);
  endtask
  task automatic wrap_up();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge i_clk);
    i_srst <= 1'b0;
    @(posedge i_clk);
    t_reset();
    t_regs();
    t_gate();
    wrap_up();
  end
  initial begin
    repeat (2000) @(posedge i_clk);
    n_fail++;
    wrap_up();
  end
endmodule // peripheral_sleep_clock_gating_tb
